// ==== design/bdt_ctrl.sv ====
// What this block does
// (RQ1) Fast back-to-back to different secondary targets only while its enable field is 1.
// (RQ2) Primary timeout field: 0 selects 2^15 clocks, 1 selects 2^10 clocks.
// (RQ3) Secondary timeout field: 0 selects 2^15 clocks, 1 selects 2^10 clocks.
// (RQ4) Timeout count starts as soon as a delayed transaction reaches queue head; a head in the same cycle as a repeat starts no count while a count is running.
// (RQ5) Initiator must repeat before expiry, otherwise the transaction is discarded.
// (RQ6) Either count expiring sets timeout status; software clears it writing one.
// (RQ7) Discard error enable set and a timer expiring asserts primary system error.
// (RQ8) Bits 31 to 28 of the control register always read as zero.
// (RQ9) Reset clears all control fields and the timeout status flag.
// (RQ10) A repeated request stops the count so the transaction is kept.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bdt_defines.svh"

module bdt_ctrl #(
	parameter int TMO_LONG_CLKS = `BDT_TMO_LONG_CLKS,
	parameter int TMO_SHORT_CLKS = `BDT_TMO_SHORT_CLKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic p_dly_head,
	input wire logic p_dly_repeat,
	output logic p_dly_discard,
	input wire logic s_dly_head,
	input wire logic s_dly_repeat,
	output logic s_dly_discard,
	output logic fbb_allow,
	output logic primary_system_error_n,
	output logic primary_system_error_oe_n,
	output logic irq
);

	function automatic logic [15:0] tmo_last(input logic short_sel);
		tmo_last = short_sel ? 16'(TMO_SHORT_CLKS - 1) : 16'(TMO_LONG_CLKS - 1);
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		lane_merge = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				lane_merge[8*b +: 8] = new_v[8*b +: 8];
			end
		end
	endfunction

	// Control fields, bits 27..23 of the control word
	logic [4:0] ctrl_r, ctrl_nxt;
	logic [1:0] istat_r, istat_nxt;
	logic [1:0] imask_r, imask_nxt;

	// Bus slave state
	logic aw_have_r, aw_have_nxt;
	logic w_have_r, w_have_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// Discard timers, index 0 primary, 1 secondary
	bdt_pkg::bdt_tmr_state_t tst_r [2];
	bdt_pkg::bdt_tmr_state_t tst_nxt [2];
	logic [15:0] tcnt_r [2];
	logic [15:0] tcnt_nxt [2];
	logic [1:0] head, rep, expire, tsel;
	logic [1:0] discard_r, discard_nxt;
	logic serr_r, serr_nxt;

	logic do_write;
	logic [31:0] ctrl_word;
	logic [31:0] wr_val;

	assign head = {s_dly_head, p_dly_head};
	assign rep = {s_dly_repeat, p_dly_repeat};
	assign tsel = {ctrl_r[`BDT_BIT_STO - `BDT_CTRL_LO], ctrl_r[`BDT_BIT_PTO - `BDT_CTRL_LO]};
	// Upper nibble and lower control bits are outside this block and read zero
	assign ctrl_word = {4'h0, ctrl_r, 23'h00_0000}; // RQ8
	assign do_write = aw_have_r && w_have_r && !bvalid_r;

	// Timer group
	always_comb begin
		expire = 2'b00;
		for (int i = 0; i < 2; i++) begin
			tst_nxt[i] = tst_r[i];
			tcnt_nxt[i] = tcnt_r[i];
			case (tst_r[i])
				bdt_pkg::BDT_IDLE: begin
					if (head[i]) begin
						tst_nxt[i] = bdt_pkg::BDT_RUN; // RQ4
						tcnt_nxt[i] = 16'h0000;
					end
				end
				bdt_pkg::BDT_RUN: begin
					if (rep[i]) begin
						// A repeat beats an expiry in the same cycle
						tst_nxt[i] = bdt_pkg::BDT_IDLE; // RQ10
					end else if (tcnt_r[i] >= tmo_last(tsel[i])) begin // RQ2 RQ3
						expire[i] = 1'b1; // RQ5
						tst_nxt[i] = head[i] ? bdt_pkg::BDT_RUN : bdt_pkg::BDT_IDLE;
						tcnt_nxt[i] = 16'h0000;
					end else if (head[i]) begin
						// A new head restarts the count for that transaction
						tcnt_nxt[i] = 16'h0000; // RQ4
					end else begin
						tcnt_nxt[i] = tcnt_r[i] + 16'h0001;
					end
				end
				default: tst_nxt[i] = bdt_pkg::BDT_IDLE;
			endcase
		end
		discard_nxt = expire; // RQ5
		serr_nxt = (|expire) && ctrl_r[`BDT_BIT_DERR - `BDT_CTRL_LO]; // RQ7
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 2; i++) begin
				tst_r[i] <= bdt_pkg::BDT_IDLE;
				tcnt_r[i] <= 16'h0000;
			end
			discard_r <= 2'b00;
			serr_r <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				tst_r[i] <= tst_nxt[i];
				tcnt_r[i] <= tcnt_nxt[i];
			end
			discard_r <= discard_nxt;
			serr_r <= serr_nxt;
		end
	end

	// Register group
	always_comb begin
		ctrl_nxt = ctrl_r;
		istat_nxt = istat_r;
		imask_nxt = imask_r;
		wr_val = 32'h0000_0000;
		if (do_write) begin
			case (awaddr_r)
				`BDT_OFS_CTRL: begin
					wr_val = lane_merge(ctrl_word, wdata_r, wstrb_r);
					ctrl_nxt[`BDT_BIT_FBB - `BDT_CTRL_LO] = wr_val[`BDT_BIT_FBB];
					ctrl_nxt[`BDT_BIT_PTO - `BDT_CTRL_LO] = wr_val[`BDT_BIT_PTO];
					ctrl_nxt[`BDT_BIT_STO - `BDT_CTRL_LO] = wr_val[`BDT_BIT_STO];
					ctrl_nxt[`BDT_BIT_DERR - `BDT_CTRL_LO] = wr_val[`BDT_BIT_DERR];
					if (wstrb_r[3] && wdata_r[`BDT_BIT_TOS]) begin
						ctrl_nxt[`BDT_BIT_TOS - `BDT_CTRL_LO] = 1'b0; // RQ6
					end
				end
				`BDT_OFS_ISTAT: begin
					if (wstrb_r[0]) begin
						istat_nxt = istat_r & ~wdata_r[1:0];
					end
				end
				`BDT_OFS_IMASK: begin
					if (wstrb_r[0]) begin
						imask_nxt = wdata_r[1:0];
					end
				end
				default: wr_val = 32'h0000_0000;
			endcase
		end
		// Hardware set wins over a same-cycle software clear
		if (|expire) begin
			ctrl_nxt[`BDT_BIT_TOS - `BDT_CTRL_LO] = 1'b1; // RQ6
		end
		istat_nxt = istat_nxt | expire;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `BDT_CTRL_RST; // RQ9
			istat_r <= `BDT_IRQ_RST;
			imask_r <= `BDT_IRQ_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
		end
	end

	// Bus group: one write and one read in flight
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case (awaddr_r)
				`BDT_OFS_CTRL, `BDT_OFS_ISTAT, `BDT_OFS_IMASK: bresp_nxt = `BDT_RESP_OKAY;
				default: bresp_nxt = `BDT_RESP_SLVERR;
			endcase
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `BDT_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`BDT_OFS_CTRL: rdata_nxt = ctrl_word;
				`BDT_OFS_ISTAT: rdata_nxt = {30'h0000_0000, istat_r};
				`BDT_OFS_IMASK: rdata_nxt = {30'h0000_0000, imask_r};
				`BDT_OFS_TSTAT: rdata_nxt = {30'h0000_0000, tst_r[1] == bdt_pkg::BDT_RUN,
					tst_r[0] == bdt_pkg::BDT_RUN};
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = `BDT_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `BDT_RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= `BDT_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	assign fbb_allow = ctrl_r[`BDT_BIT_FBB - `BDT_CTRL_LO]; // RQ1
	assign p_dly_discard = discard_r[0];
	assign s_dly_discard = discard_r[1];
	// Open-drain style: value is always low, enable low only while pulling
	assign primary_system_error_n = 1'b0;
	assign primary_system_error_oe_n = !serr_r; // RQ7
	assign irq = |(istat_r & imask_r);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_fbb_follows: assert property ($rose(fbb_allow) |-> $past(do_write && wstrb_r[2] // RQ1
		&& awaddr_r == `BDT_OFS_CTRL && wdata_r[`BDT_BIT_FBB]))
		else $error("fast back-to-back enabled without a control write");
	a_pri_limit: assert property (tst_r[0] == bdt_pkg::BDT_RUN && !p_dly_repeat // RQ2
		&& tcnt_r[0] == (ctrl_r[1] ? 16'(TMO_SHORT_CLKS - 1) : 16'(TMO_LONG_CLKS - 1))
		|=> p_dly_discard)
		else $error("primary timeout did not discard at its limit");
	a_sec_limit: assert property (tst_r[1] == bdt_pkg::BDT_RUN && !s_dly_repeat // RQ3
		&& tcnt_r[1] == (ctrl_r[2] ? 16'(TMO_SHORT_CLKS - 1) : 16'(TMO_LONG_CLKS - 1))
		|=> s_dly_discard)
		else $error("secondary timeout did not discard at its limit");
	a_count_start: assert property (p_dly_head && !expire[0] // RQ4
		&& !(tst_r[0] == bdt_pkg::BDT_RUN && p_dly_repeat)
		|=> tst_r[0] == bdt_pkg::BDT_RUN && tcnt_r[0] == 16'h0000)
		else $error("primary count did not start at head");
	a_discard_pulse: assert property (expire[0] |=> p_dly_discard ##1 !p_dly_discard) // RQ5
		else $error("primary discard not a single pulse");
	a_status_set: assert property (|expire |=> ctrl_r[3] && s_axi_rdata[31:28] == 4'h0) // RQ6
		else $error("timeout status not set on expiry");
	a_serr_fire: assert property (|expire && ctrl_r[4] |=> !primary_system_error_oe_n) // RQ7
		else $error("system error not driven on expiry");
	a_serr_quiet: assert property (!ctrl_r[4] |=> primary_system_error_oe_n) // RQ7
		else $error("system error driven while disabled");
	a_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:28] == 4'h0) // RQ8
		else $error("reserved bits read nonzero");
	a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0) // RQ9
		!$past(aresetn) |-> ctrl_r == 5'h00 && primary_system_error_oe_n)
		else $error("control fields not cleared by reset");
	a_repeat_stop: assert property (tst_r[1] == bdt_pkg::BDT_RUN && s_dly_repeat // RQ10
		&& !s_dly_head |=> tst_r[1] == bdt_pkg::BDT_IDLE ##1 !s_dly_discard)
		else $error("secondary count not stopped by repeat");

	c_pri_expire: cover property (expire[0]);
	c_sec_repeat: cover property (tst_r[1] == bdt_pkg::BDT_RUN && s_dly_repeat);
	c_serr: cover property (!primary_system_error_oe_n);
	c_irq_clear: cover property (irq ##[1:20] !irq);

endmodule

// ==== include/bdt_defines.svh ====
`ifndef BDT_DEFINES_SVH
`define BDT_DEFINES_SVH

// Register byte offsets
`define BDT_OFS_CTRL 8'h00
`define BDT_OFS_ISTAT 8'h04
`define BDT_OFS_IMASK 8'h08
`define BDT_OFS_TSTAT 8'h0C

// Control field positions
`define BDT_BIT_FBB 23
`define BDT_BIT_PTO 24
`define BDT_BIT_STO 25
`define BDT_BIT_TOS 26
`define BDT_BIT_DERR 27
`define BDT_CTRL_LO 23
`define BDT_CTRL_HI 27
`define BDT_CTRL_RST 5'h00
`define BDT_IRQ_RST 2'h0

// Timeout figures in PCI clocks (one aclk per PCI clock)
`define BDT_TMO_LONG_CLKS 32768
`define BDT_TMO_SHORT_CLKS 1024

// AXI responses
`define BDT_RESP_OKAY 2'h0
`define BDT_RESP_SLVERR 2'h2

`endif

// ==== include/bdt_pkg.sv ====
package bdt_pkg;
	typedef enum logic {
		BDT_IDLE = 1'b0,
		BDT_RUN = 1'b1
	} bdt_tmr_state_t;
endpackage

// ==== verification/bdt_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "bdt_defines.svh"
module bdt_ctrl_tb;
	localparam int LONG = 40;
	localparam int SHORT = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic go_p = 1'b0, go_s = 1'b0, rep_en = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, fbb, serr, oe_n, irq;
	logic p_head, p_rep, p_disc, s_head, s_rep, s_disc;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, c;
	int err_total = 0;
	int total_checks = 0;

	always #4 aclk = ~aclk;

	bdt_ctrl #(.TMO_LONG_CLKS(LONG), .TMO_SHORT_CLKS(SHORT)) uut (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.p_dly_head(p_head), .p_dly_repeat(p_rep), .p_dly_discard(p_disc),
		.s_dly_head(s_head), .s_dly_repeat(s_rep), .s_dly_discard(s_disc),
		.fbb_allow(fbb), .primary_system_error_n(serr),
		.primary_system_error_oe_n(oe_n), .irq(irq));
	bdt_init_model prim_init (.aclk(aclk), .go(go_p), .rep_en(rep_en), .head(p_head),
		.rep(p_rep));
	bdt_init_model sec_init (.aclk(aclk), .go(go_s), .rep_en(rep_en), .head(s_head),
		.rep(s_rep));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tmo();
		err_total++;
		$display("BAD %0t no answer from slave", $time);
		finish_test();
	endtask

	// Handshakes are judged at the falling edge, where everything has settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		// One idle edge, so a following call never re-drives a released strobe in this step
		@(posedge aclk);
		if (n == 50) tmo();
		chk(32'(r), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		@(posedge aclk);
		if (n == 50) tmo();
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	// Counts clocks from the cycle the head pulse is sampled to the discard pulse
	task automatic tmr(input logic sec, input logic re, input int e, input logic derr);
		int n, k;
		logic d, o;
		rep_en <= re;
		if (sec) go_s <= 1'b1;
		else go_p <= 1'b1;
		@(posedge aclk);
		go_s <= 1'b0;
		go_p <= 1'b0;
		k = -1;
		d = 1'b0;
		o = 1'b1;
		for (n = 0; n < 100 && !d; n++) begin
			@(negedge aclk);
			if (k >= 0) k++;
			if (sec ? s_head : p_head) k = 0;
			d = sec ? s_disc : p_disc;
			o = oe_n;
		end
		@(posedge aclk);
		if (re) begin
			chk(32'(d), 32'h0000_0000);
		end else begin
			chk(32'(k), 32'(e));
			chk(32'(o), 32'(!derr));
		end
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`BDT_OFS_CTRL, 32'h0000_0000, `BDT_RESP_OKAY);
		chk(32'(fbb), 32'h0000_0000);
		chk(32'(serr), 32'h0000_0000);
		$display("reset test done");
		wr(`BDT_OFS_CTRL, 32'hFFFF_FFFF, `BDT_RESP_OKAY);
		rd(`BDT_OFS_CTRL, 32'h0B80_0000, `BDT_RESP_OKAY);
		chk(32'(fbb), 32'h0000_0001);
		// A reset in mid-run must clear the fields that were just set
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`BDT_OFS_CTRL, 32'h0000_0000, `BDT_RESP_OKAY);
		chk(32'(fbb), 32'h0000_0000);
		rd(8'h10, 32'h0000_0000, `BDT_RESP_SLVERR);
		wr(`BDT_OFS_TSTAT, 32'h0000_0003, `BDT_RESP_SLVERR);
		wr(`BDT_OFS_IMASK, 32'h0000_0001, `BDT_RESP_OKAY);
		$display("register test done");
		// Both sides, both timeout selections, error enable toggled
		for (int i = 0; i < 4; i++) begin
			// The idle side gets the opposite selection, so a swapped field shows up
			c = {4'h0, i[0] ^ i[1], 1'b1, i[1] ^ !i[0], i[1] ^ i[0], 24'h00_0000};
			wr(`BDT_OFS_CTRL, c, `BDT_RESP_OKAY);
			tmr(i[0], 1'b0, (i[1] ? SHORT : LONG) + 1, i[0] ^ i[1]);
			rd(`BDT_OFS_CTRL, c, `BDT_RESP_OKAY);
			chk(32'(irq), 32'(!i[0]));
			wr(`BDT_OFS_ISTAT, 32'h0000_0003, `BDT_RESP_OKAY);
			chk(32'(irq), 32'h0000_0000);
		end
		wr(`BDT_OFS_CTRL, 32'h0400_0000, `BDT_RESP_OKAY);
		rd(`BDT_OFS_CTRL, 32'h0000_0000, `BDT_RESP_OKAY);
		$display("timer test done");
		tmr(1'b0, 1'b1, 0, 1'b0);
		tmr(1'b1, 1'b1, 0, 1'b0);
		rd(`BDT_OFS_CTRL, 32'h0000_0000, `BDT_RESP_OKAY);
		$display("repeat test done");
		// A running count shows in the timer status word
		go_p <= 1'b1;
		@(posedge aclk);
		go_p <= 1'b0;
		@(posedge aclk);
		rd(`BDT_OFS_TSTAT, 32'h0000_0001, `BDT_RESP_OKAY);
		$display("status test done");
		finish_test();
	end
endmodule

// ==== verification/bdt_init_model.sv ====
`timescale 1ns/1ps
// Queue-head and repeat pulses of one PCI initiator, one pulse per request
module bdt_init_model (
	input wire logic aclk,
	input wire logic go,
	input wire logic rep_en,
	output logic head,
	output logic rep
);
	int cnt;
	initial begin
		head = 1'b0;
		rep = 1'b0;
		cnt = -1;
	end
	// The repeat lands a few clocks after the head, inside even the short timeout
	always @(posedge aclk) begin
		head <= go;
		rep <= (cnt == 3);
		if (go) begin
			cnt <= rep_en ? 0 : -1;
		end else if (cnt >= 0 && cnt < 4) begin
			cnt <= cnt + 1;
		end
	end
endmodule
